// ### core/dps_pkg.sv
/*
 * Constants for the precharge / self-refresh block: register map, field positions,
 * reset values, command encodings and timing counts.
 * Assumes a single 20 MHz clock with all inputs synchronous to it.
 */
// Summary of operation
// - precharge uses A10 for one bank or all; bank address picks the single bank
// - precharge to all banks ignores the bank address inputs
// - refresh registered with CKE low enters self-refresh instead of plain refresh
// - DLL switches off at self-refresh entry, back on with reset at exit
// - in self-refresh every control input except CKE and reset is ignored
// - at least one internal refresh occurs within the minimum CKE pulse period
// - exit and DLL exit timers start at first clock edge seeing CKE high
// - mode register two bit 6 set makes self-refresh rate follow temperature
package dps_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // register map
   localparam logic [3:0] REG_MODE_TWO   = 4'h0;
   localparam logic [3:0] REG_STATUS     = 4'h4;
   localparam logic [3:0] REG_REF_COUNT  = 4'h8;

   localparam int         MODE_AUTO_BIT  = 6;
   localparam int         MODE_RANGE_BIT = 7;
   localparam logic [1:0] MODE_RESET     = 2'h0;

   localparam int         ST_BANK_LSB    = 0;
   localparam int         ST_XS_OK_BIT   = 8;
   localparam int         ST_DLL_ON_BIT  = 9;
   localparam int         ST_SELF_BIT    = 10;

   ////////////////////////////////////////////////////////////////////////////////
   // commands as {ras_n, cas_n, we_n} with cs_n low
   localparam logic [2:0] CMD_ACTIVATE   = 3'h3;
   localparam logic [2:0] CMD_PRECHARGE  = 3'h2;
   localparam logic [2:0] CMD_REFRESH    = 3'h1;

   ////////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int         CLK_PERIOD_NS  = 50;
   localparam int         TCKE_NS        = 5;
   localparam int         TXS_NS         = 170;
   localparam int         REFI_NORMAL_NS = 7800;
   localparam int         REFI_EXT_NS    = 3900;

   localparam logic [9:0] TCKE_CK   = 10'((TCKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [9:0] TXS_CK    = 10'((TXS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [9:0] TXSDLL_CK = 10'h200;
   localparam logic [7:0] REFI_NORMAL_CK = 8'(REFI_NORMAL_NS / CLK_PERIOD_NS);
   localparam logic [7:0] REFI_EXT_CK    = 8'(REFI_EXT_NS / CLK_PERIOD_NS);

   typedef enum logic [1:0] {
      DPS_NORMAL,
      DPS_SELF,
      DPS_EXIT
   } dps_state_t;

endpackage : dps_pkg

// ### core/dps_rtmr_if.sv
/*
 * Carrier between the self-refresh sequencer and its internal refresh timer.
 * Assumes both ends share ref_clk.
 */
`timescale 1ns/100ps
`default_nettype none
interface dps_rtmr_if;
   logic run;    // self-refresh in progress
   logic fast;   // doubled internal refresh rate
   logic tick;   // one internal refresh

   modport ctrl  (output run, output fast, input tick);
   modport timer (input run, input fast, output tick);
endinterface : dps_rtmr_if
`default_nettype wire

// ### core/dps_refresh_timer.sv
/*
 * Internal refresh timer used during self-refresh.
 * Assumes run rises on the first self-refresh cycle and stays high until exit.
 */
`timescale 1ns/100ps
`default_nettype none
module dps_refresh_timer (
   // clock and reset
   input  wire logic   ref_clk,
   input  wire logic   rst_n,
   // sequencer side
   dps_rtmr_if.timer   rt
);
   logic [7:0] cnt_q;
   logic       run_q;
   logic       tick_q;

   assign rt.tick = tick_q;

   ////////////////////////////////////////////////////////////////////////////////
   // first refresh right at the start, well inside the minimum CKE pulse
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         run_q  <= 1'b0;
         cnt_q  <= 8'h00;
         tick_q <= 1'b0;
      end else begin
         run_q  <= rt.run;
         tick_q <= 1'b0;
         if (!rt.run) begin
            cnt_q <= 8'h00;
         end else if (!run_q || cnt_q == 8'h00) begin
            tick_q <= 1'b1;
            cnt_q  <= (rt.fast ? dps_pkg::REFI_EXT_CK : dps_pkg::REFI_NORMAL_CK) - 8'h01;
         end else begin
            cnt_q <= cnt_q - 8'h01;
         end
      end
   end

endmodule : dps_refresh_timer
`default_nettype wire

// ### core/dps_core.sv
/*
 * Device-side precharge and self-refresh sequencer for a DDR3-style memory.
 * Assumes command pins and CKE synchronous to ref_clk; registers over a plain port.
 */
`timescale 1ns/100ps
`default_nettype none
module dps_core (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // memory command pins
   input  wire logic        cke,
   input  wire logic        cs_n,
   input  wire logic        ras_n,
   input  wire logic        cas_n,
   input  wire logic        we_n,
   input  wire logic        a10,
   input  wire logic [2:0]  ba,
   // case temperature above normal range
   input  wire logic        case_temp_high,
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // status
   output logic      [7:0]  bank_open,
   output logic             self_refresh,
   output logic             dll_enable,
   output logic             dll_reset,
   output logic             int_refresh,
   output logic             exit_ready
);
   dps_pkg::dps_state_t state_q;
   logic [7:0]  bank_open_q;
   logic [1:0]  mode_q;          // {temp_range_select, auto_self_refresh_enable}
   logic        dll_enable_q;
   logic        dll_reset_q;
   logic        xs_ok_q;
   logic [9:0]  cnt_q;
   logic [15:0] ref_count_q;
   logic [31:0] rdata_q;
   logic        cmd_act;
   logic        cmd_pre;
   logic        cmd_ref;
   logic        sr_enter;
   logic        sr_leave;
   logic        sr_take;

   dps_rtmr_if rt ();

   dps_refresh_timer u_timer (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .rt      (rt)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // command decode
   assign cmd_act  = !cs_n && {ras_n, cas_n, we_n} == dps_pkg::CMD_ACTIVATE;
   assign cmd_pre  = !cs_n && {ras_n, cas_n, we_n} == dps_pkg::CMD_PRECHARGE;
   assign cmd_ref  = !cs_n && {ras_n, cas_n, we_n} == dps_pkg::CMD_REFRESH;
   assign sr_enter = cmd_ref && !cke && state_q != dps_pkg::DPS_SELF;
   assign sr_leave = state_q == dps_pkg::DPS_SELF && cke;
   // re-entry inside the exit window is refused, so it must not touch dll or status
   assign sr_take  = sr_enter && (state_q == dps_pkg::DPS_NORMAL || xs_ok_q);

   assign rt.run  = state_q == dps_pkg::DPS_SELF;
   // auto mode doubles only when hot; extended range always runs fast
   assign rt.fast = mode_q[1] || (mode_q[0] && case_temp_high);

   ////////////////////////////////////////////////////////////////////////////////
   // self-refresh state and exit timers
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_q <= dps_pkg::DPS_NORMAL;
         cnt_q   <= 10'h000;
         xs_ok_q <= 1'b1;
      end else begin
         case (state_q)
            dps_pkg::DPS_NORMAL: begin
               if (sr_enter) begin
                  state_q <= dps_pkg::DPS_SELF;
                  xs_ok_q <= 1'b0;
               end
            end
            dps_pkg::DPS_SELF: begin
               // exit may be asynchronous, but timing counts from this edge
               if (cke) begin
                  state_q <= dps_pkg::DPS_EXIT;
                  cnt_q   <= 10'h001;
               end
            end
            default: begin
               cnt_q <= cnt_q + 10'h001;
               if (cnt_q == dps_pkg::TXS_CK) begin
                  xs_ok_q <= 1'b1;
               end
               if (sr_enter && xs_ok_q) begin
                  state_q <= dps_pkg::DPS_SELF;
                  xs_ok_q <= 1'b0;
               end else if (cnt_q == dps_pkg::TXSDLL_CK) begin
                  state_q <= dps_pkg::DPS_NORMAL;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // dll control
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         dll_enable_q <= 1'b1;
         dll_reset_q  <= 1'b0;
      end else begin
         dll_reset_q <= 1'b0;
         if (sr_take) begin
            dll_enable_q <= 1'b0;
         end else if (sr_leave) begin
            dll_enable_q <= 1'b1;
            dll_reset_q  <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // bank state; pins other than cke are dead during self-refresh
   generate
      for (genvar b = 0; b < 8; b++) begin : g_bank
         always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
               bank_open_q[b] <= 1'b0;
            end else if (state_q != dps_pkg::DPS_SELF) begin
               if (cmd_act && ba == 3'(b)) begin
                  bank_open_q[b] <= 1'b1;
               end else if (cmd_pre && (a10 || ba == 3'(b))) begin
                  bank_open_q[b] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         mode_q <= dps_pkg::MODE_RESET;
      end else if (reg_wr && reg_addr == dps_pkg::REG_MODE_TWO) begin
         // illegal pair is stored as written; software must avoid it
         mode_q <= {reg_wdata[dps_pkg::MODE_RANGE_BIT], reg_wdata[dps_pkg::MODE_AUTO_BIT]};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ref_count_q <= 16'h0000;
      end else if (reg_wr && reg_addr == dps_pkg::REG_REF_COUNT) begin
         ref_count_q <= 16'h0000;
      end else if (rt.tick) begin
         ref_count_q <= ref_count_q + 16'h0001;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= 32'h0000_0000;
         if (reg_rd) begin
            if (reg_addr == dps_pkg::REG_MODE_TWO) begin
               rdata_q[dps_pkg::MODE_RANGE_BIT] <= mode_q[1];
               rdata_q[dps_pkg::MODE_AUTO_BIT]  <= mode_q[0];
            end else if (reg_addr == dps_pkg::REG_STATUS) begin
               rdata_q[dps_pkg::ST_BANK_LSB +: 8] <= bank_open_q;
               rdata_q[dps_pkg::ST_XS_OK_BIT]     <= xs_ok_q;
               rdata_q[dps_pkg::ST_DLL_ON_BIT]    <= dll_enable_q;
               rdata_q[dps_pkg::ST_SELF_BIT]      <= state_q == dps_pkg::DPS_SELF;
            end else if (reg_addr == dps_pkg::REG_REF_COUNT) begin
               rdata_q[15:0] <= ref_count_q;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs
   logic self_q;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         self_q <= 1'b0;
      end else begin
         self_q <= (state_q == dps_pkg::DPS_SELF && !cke) || sr_take;
      end
   end

   assign reg_rdata    = rdata_q;
   assign bank_open    = bank_open_q;
   assign self_refresh = self_q;
   assign dll_enable   = dll_enable_q;
   assign dll_reset    = dll_reset_q;
   assign int_refresh  = rt.tick;
   assign exit_ready   = xs_ok_q;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   chk_pre_single: assert property (
      cmd_pre && !a10 && state_q != dps_pkg::DPS_SELF |=> !bank_open_q[$past(ba)])
      else $error("single bank not closed");
   chk_pre_all: assert property (
      cmd_pre && a10 && !cmd_act && state_q != dps_pkg::DPS_SELF |=> bank_open_q == 8'h00)
      else $error("all banks not closed");
   chk_sr_entry: assert property (
      sr_enter && state_q == dps_pkg::DPS_NORMAL |=> state_q == dps_pkg::DPS_SELF && self_q)
      else $error("self-refresh not entered");
   chk_dll_off: assert property (
      state_q == dps_pkg::DPS_SELF |-> !dll_enable_q)
      else $error("dll on during self-refresh");
   chk_dll_reset: assert property (
      sr_leave |=> dll_reset_q && dll_enable_q ##1 !dll_reset_q)
      else $error("dll not reset at exit");
   chk_sr_ignore: assert property (
      state_q == dps_pkg::DPS_SELF && (cmd_act || cmd_pre) |=> $stable(bank_open_q))
      else $error("command obeyed in self-refresh");
   chk_int_refresh: assert property (
      sr_enter && state_q == dps_pkg::DPS_NORMAL ##1 !cke |-> ##1 rt.tick)
      else $error("no internal refresh after entry");
   chk_exit_timer: assert property (
      sr_leave |=> !xs_ok_q [*4] ##1 xs_ok_q)
      else $error("exit time wrong");
   chk_rate_mode: assert property (
      mode_q == 2'h1 |-> rt.fast == case_temp_high)
      else $error("auto rate ignores temperature");

   cov_sr_cycle:  cover property (sr_enter ##[1:1000] sr_leave);
   cov_exit_done: cover property (state_q == dps_pkg::DPS_EXIT && cnt_q == dps_pkg::TXSDLL_CK);
   cov_pre_all:   cover property (cmd_pre && a10 && bank_open_q != 8'h00);

endmodule : dps_core
`default_nettype wire

// ### tb/dps_ctrl_model.sv
/*
 * Memory-controller model driving command pins and CKE of the device.
 * Assumes the device samples every pin on the rising edge of ref_clk.
 */
`timescale 1ns/100ps
`default_nettype none
module dps_ctrl_model (
   // clock
   input  wire logic       ref_clk,
   // command pins toward the device
   output var  logic       cke,
   output var  logic       cs_n,
   output var  logic       ras_n,
   output var  logic       cas_n,
   output var  logic       we_n,
   output var  logic       a10,
   output var  logic [2:0] ba
);
   int seed = 30;

   initial begin
      cke = 1'b1;
      {cs_n, ras_n, cas_n, we_n, a10, ba} = 8'hf8;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // deselect: unused pins wander so a stale value is never trusted
   task automatic idle();
      cs_n <= 1'b1;
      {ras_n, cas_n, we_n, a10, ba} <= 7'($random(seed));
   endtask : idle

   // one command, then deselect; never a write, termination, calibration or timed refresh
   task automatic issue(input logic [2:0] cmd, input logic ck, input logic all,
                        input logic [2:0] bank);
      @(posedge ref_clk);
      cke <= ck;
      cs_n <= 1'b0;
      {ras_n, cas_n, we_n} <= cmd;
      a10 <= all;
      ba <= bank;
      @(posedge ref_clk);
      idle();
   endtask : issue

   // garbage on every pin but cke while the device sleeps
   task automatic noise(input int n);
      repeat (n) begin
         @(posedge ref_clk);
         {cs_n, ras_n, cas_n, we_n, a10, ba} <= 8'($random(seed));
      end
      @(posedge ref_clk);
      idle();
   endtask : noise

   task automatic set_cke(input logic ck);
      @(posedge ref_clk);
      cke <= ck;
      idle();
   endtask : set_cke
endmodule : dps_ctrl_model
`default_nettype wire

// ### tb/dram_precharge_self_refresh_bench.sv
/*
 * Self-checking bench for the precharge and self-refresh block.
 * Assumes the controller model drives the command pins; registers read here.
 */
`timescale 1ns/100ps
`default_nettype none
module dram_precharge_self_refresh_bench;
   logic        ref_clk, rst_n, cke, cs_n, ras_n, cas_n, we_n, a10, case_temp_high;
   logic        reg_wr, reg_rd, rd_d, self_refresh, dll_enable, dll_reset;
   logic        int_refresh, exit_ready;
   logic [2:0]  ba;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [7:0]  bank_open, exp_banks;
   logic [31:0] exp_q[$];
   logic [3:0]  adr_q[$];
   int          n_mismatch = 0;
   int          checks_done = 0;
   int          seed = 30;
   int          n;

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   dps_core dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .a10(a10), .ba(ba), .case_temp_high(case_temp_high),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .bank_open(bank_open), .self_refresh(self_refresh),
      .dll_enable(dll_enable), .dll_reset(dll_reset), .int_refresh(int_refresh),
      .exit_ready(exit_ready));

   dps_ctrl_model ctl_u (.ref_clk(ref_clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .a10(a10), .ba(ba));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : finish_test

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         n_mismatch++;
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // expected value is queued; the watcher below compares it
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      exp_q.push_back(e);
      adr_q.push_back(a);
      @(posedge ref_clk);
      reg_rd <= 1'b0;
   endtask : rd

   function automatic logic [31:0] stat(input logic [7:0] b, input logic xr, dll, sr);
      stat = 32'(b) << dps_pkg::ST_BANK_LSB;
      stat[dps_pkg::ST_XS_OK_BIT] = xr;
      stat[dps_pkg::ST_DLL_ON_BIT] = dll;
      stat[dps_pkg::ST_SELF_BIT] = sr;
   endfunction : stat

   // bounded wait for a pulse or level: 0 refresh, 1 dll reset, 2 exit ready
   task automatic wait_hi(input int sel, input int lim, output int cnt);
      logic s;
      cnt = 0;
      do begin
         @(negedge ref_clk);
         cnt++;
         s = (sel == 0) ? int_refresh : (sel == 1) ? dll_reset : exit_ready;
      end while (s !== 1'b1 && cnt < lim);
      if (s !== 1'b1) begin
         $display("CHECK FAILED wait %0d expected 1 seen %b", sel, s);
         n_mismatch++;
         finish_test();
      end
   endtask : wait_hi

   always @(posedge ref_clk) rd_d <= reg_rd;
   always @(negedge ref_clk) begin
      if (rd_d === 1'b1) begin
         if (exp_q.size() == 0) begin
            $display("CHECK FAILED read expected none seen %h", reg_rdata);
            n_mismatch++;
         end else
            chk($sformatf("reg_%0h", adr_q.pop_front()), exp_q.pop_front(), reg_rdata);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // one full self-refresh stay; gap is the expected refresh spacing
   task automatic sr_run(input logic [1:0] mode, input logic hot, input int gap);
      wr(4'h0, {24'h0, mode, 6'h00});
      case_temp_high <= hot;
      ctl_u.issue(dps_pkg::CMD_PRECHARGE, 1'b1, 1'b1, 3'($random(seed)));
      exp_banks = 8'h00;
      wr(4'h8, 32'h0);
      ctl_u.issue(dps_pkg::CMD_REFRESH, 1'b0, 1'b0, 3'h0);
      @(negedge ref_clk);
      chk("self_refresh", 32'h1, 32'(self_refresh));
      chk("dll_enable", 32'h0, 32'(dll_enable));
      wait_hi(0, 3, n);
      ctl_u.noise(12);
      rd(4'h4, stat(exp_banks, 1'b0, 1'b0, 1'b1));
      wait_hi(0, 200, n);
      wait_hi(0, 200, n);
      chk("refresh_gap", 32'(gap), 32'(n));
      rd(4'h8, 32'h3);
      ctl_u.set_cke(1'b1);
      wait_hi(1, 4, n);
      chk("dll_enable", 32'h1, 32'(dll_enable));
      chk("self_refresh", 32'h0, 32'(self_refresh));
      wait_hi(2, 10, n);
      chk("exit_wait", 32'(dps_pkg::TXS_CK), 32'(n));
   endtask : sr_run

   initial begin
      rst_n = 1'b0;
      case_temp_high = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      exp_banks = 8'h00;
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(4'h4, stat(8'h00, 1'b1, 1'b1, 1'b0));
      rd(4'h0, 32'h0);
      rd(4'h8, 32'h0);
      // status is read-only, unmapped space reads zero
      wr(4'h4, 32'hffffffff);
      wr(4'hc, 32'hffffffff);
      rd(4'h4, stat(8'h00, 1'b1, 1'b1, 1'b0));
      rd(4'hc, 32'h0);
      for (int m = 0; m < 3; m++) begin
         wr(4'h0, {24'h0, 2'(m), 6'h00});
         rd(4'h0, {24'h0, 2'(m), 6'h00});
      end
      for (int k = 0; k < 8; k++)
         ctl_u.issue(dps_pkg::CMD_ACTIVATE, 1'b1, 1'($random(seed)), 3'(k));
      exp_banks = 8'hff;
      // close one bank at a time while the others stay open
      for (int b = 0; b < 8; b++) begin
         ctl_u.issue(dps_pkg::CMD_PRECHARGE, 1'b1, 1'b0, 3'(b));
         exp_banks[b] = 1'b0;
         rd(4'h4, stat(exp_banks, 1'b1, 1'b1, 1'b0));
         chk("bank_open", 32'(exp_banks), 32'(bank_open));
      end
      for (int k = 0; k < 8; k++)
         ctl_u.issue(dps_pkg::CMD_ACTIVATE, 1'b1, 1'b0, 3'(k));
      ctl_u.issue(dps_pkg::CMD_PRECHARGE, 1'b1, 1'b1, 3'($random(seed)));
      rd(4'h4, stat(8'h00, 1'b1, 1'b1, 1'b0));
      chk("bank_open", 32'h0, 32'(bank_open));
      // refresh with cke high stays an ordinary refresh
      ctl_u.issue(dps_pkg::CMD_REFRESH, 1'b1, 1'b0, 3'h0);
      @(negedge ref_clk);
      chk("self_refresh", 32'h0, 32'(self_refresh));
      sr_run(2'b01, 1'b1, int'(dps_pkg::REFI_EXT_CK));
      sr_run(2'b10, 1'b0, int'(dps_pkg::REFI_EXT_CK));
      sr_run(2'b00, 1'b0, int'(dps_pkg::REFI_NORMAL_CK));
      sr_run(2'b01, 1'b0, int'(dps_pkg::REFI_NORMAL_CK));
      // let the dll window run out so the sequencer settles back to normal
      repeat (520) @(posedge ref_clk);
      rd(4'h4, stat(8'h00, 1'b1, 1'b1, 1'b0));
      @(negedge ref_clk);
      finish_test();
   end
endmodule : dram_precharge_self_refresh_bench
`default_nettype wire
